// File: core/cfi_regs.svh
`ifndef CFI_REGS_SVH
`define CFI_REGS_SVH
`define CFI_NUM_FIFO 16
`define CFI_IDX_W 4
`define CFI_OFS_FIFO_BASE 8'h00
`define CFI_OFS_PEND 8'h40
`define CFI_OFS_MASK 8'h44
`define CFI_ADDR_W 8
`define CFI_B_TX_ROOM_EN 26
`define CFI_B_TX_HALF_EN 25
`define CFI_B_TX_DRAIN_EN 24
`define CFI_B_RX_OVR_EN 19
`define CFI_B_RX_PACK_EN 18
`define CFI_B_RX_HALF_EN 17
`define CFI_B_RX_PEND_EN 16
`define CFI_B_TX_ROOM 10
`define CFI_B_TX_HALF 9
`define CFI_B_TX_DRAIN 8
`define CFI_B_RX_OVR 3
`define CFI_B_RX_PACK 2
`define CFI_B_RX_HALF 1
`define CFI_B_RX_PEND 0
`define CFI_EN_TX_MASK 32'h0700_0000
`define CFI_EN_RX_MASK 32'h000f_0000
`define CFI_ZERO32 32'h0000_0000
`define CFI_FLAG_MASK 32'h0000_070f
`endif

// File: core/cfi_pkg.sv
package cfi_pkg;
    typedef logic [31:0] cfi_word_t;
    typedef logic [15:0] cfi_vec_t;
    typedef enum logic [1:0] {
        CFI_IDLE = 2'b00,
        CFI_RESP = 2'b01
    } cfi_bus_state_t;
endpackage

// File: core/cfi_fifo_slot.sv
`timescale 1ns/1ps
`include "cfi_regs.svh"
module cfi_fifo_slot
    import cfi_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire cfi_pkg::cfi_word_t wr_data,
    input wire logic fifo_direction_transmit,
    input wire logic fifo_full,
    input wire logic fifo_half,
    input wire logic fifo_empty,
    input wire logic rx_overrun_event,
    output cfi_pkg::cfi_word_t rd_word,
    output logic irq_req
);
    import cfi_pkg::*;

    logic [6:0] enables;
    logic [6:0] next_enables;
    logic overrun;
    logic next_overrun;
    logic tx_room_flag;
    logic tx_half_flag;
    logic tx_drained_flag;
    logic rx_packed_flag;
    logic rx_half_flag;
    logic rx_pending_flag;

    // Live views, gated by direction
    assign tx_room_flag = fifo_direction_transmit & ~fifo_full;
    assign tx_half_flag = fifo_direction_transmit & fifo_half;
    assign tx_drained_flag = fifo_direction_transmit & fifo_empty;
    assign rx_packed_flag = ~fifo_direction_transmit & fifo_full;
    assign rx_half_flag = ~fifo_direction_transmit & fifo_half;
    assign rx_pending_flag = ~fifo_direction_transmit & ~fifo_empty;

    always_comb begin
        next_enables = enables;
        next_overrun = overrun;
        if (wr_en) begin
            next_enables = {wr_data[`CFI_B_TX_ROOM_EN:`CFI_B_TX_DRAIN_EN],
                wr_data[`CFI_B_RX_OVR_EN:`CFI_B_RX_PEND_EN]};
            // Only a zero write clears; a one is ignored
            if (!wr_data[`CFI_B_RX_OVR])
                next_overrun = 1'b0;
        end
        // Set wins over a simultaneous clear
        if (rx_overrun_event && !fifo_direction_transmit)
            next_overrun = 1'b1;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            enables <= 7'h00;
            overrun <= 1'b0;
        end else begin
            enables <= next_enables;
            overrun <= next_overrun;
        end
    end

    always_comb begin
        rd_word = `CFI_ZERO32;
        rd_word[`CFI_B_TX_ROOM_EN:`CFI_B_TX_DRAIN_EN] = enables[6:4];
        rd_word[`CFI_B_RX_OVR_EN:`CFI_B_RX_PEND_EN] = enables[3:0];
        rd_word[`CFI_B_TX_ROOM] = tx_room_flag;
        rd_word[`CFI_B_TX_HALF] = tx_half_flag;
        rd_word[`CFI_B_TX_DRAIN] = tx_drained_flag;
        rd_word[`CFI_B_RX_OVR] = overrun;
        rd_word[`CFI_B_RX_PACK] = rx_packed_flag;
        rd_word[`CFI_B_RX_HALF] = rx_half_flag;
        rd_word[`CFI_B_RX_PEND] = rx_pending_flag;
    end

    assign irq_req = (enables[6] & tx_room_flag) | (enables[5] & tx_half_flag)
        | (enables[4] & tx_drained_flag) | (enables[3] & overrun)
        | (enables[2] & rx_packed_flag) | (enables[1] & rx_half_flag)
        | (enables[0] & rx_pending_flag);
endmodule

// File: core/cfi_top.sv
`timescale 1ns/1ps
`include "cfi_regs.svh"
module cfi_top
    import cfi_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire cfi_pkg::cfi_word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output cfi_pkg::cfi_word_t avs_readdata,
    output logic avs_waitrequest,
    input wire cfi_pkg::cfi_vec_t fifo_direction_transmit,
    input wire cfi_pkg::cfi_vec_t fifo_full,
    input wire cfi_pkg::cfi_vec_t fifo_half,
    input wire cfi_pkg::cfi_vec_t fifo_empty,
    input wire cfi_pkg::cfi_vec_t rx_overrun_event,
    output cfi_pkg::cfi_vec_t fifo_irq_req,
    output logic irq
);
    import cfi_pkg::*;

    cfi_bus_state_t state;
    cfi_bus_state_t next_state;
    cfi_word_t rdata;
    cfi_word_t next_rdata;
    cfi_vec_t pend;
    cfi_vec_t next_pend;
    cfi_vec_t mask;
    cfi_vec_t next_mask;
    cfi_vec_t req_d;
    cfi_vec_t slot_wr;
    cfi_word_t slot_rd [`CFI_NUM_FIFO];
    cfi_word_t be_mask;
    cfi_word_t merged;
    logic access;
    logic in_fifo;
    logic [`CFI_IDX_W-1:0] idx;

    assign access = (avs_read | avs_write) && state == CFI_IDLE;
    assign in_fifo = avs_address < `CFI_OFS_PEND;
    assign idx = avs_address[5:2];
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // Unwritten lanes keep current contents
    assign merged = (avs_writedata & be_mask) | (slot_rd[idx] & ~be_mask);

    genvar g;
    generate
        for (g = 0; g < `CFI_NUM_FIFO; g = g + 1) begin : g_slot
            assign slot_wr[g] = access && avs_write && in_fifo
                && idx == g;
            cfi_fifo_slot u_slot (
                .clock(clock),
                .resetn(resetn),
                .wr_en(slot_wr[g]),
                .wr_data(merged),
                .fifo_direction_transmit(fifo_direction_transmit[g]),
                .fifo_full(fifo_full[g]),
                .fifo_half(fifo_half[g]),
                .fifo_empty(fifo_empty[g]),
                .rx_overrun_event(rx_overrun_event[g]),
                .rd_word(slot_rd[g]),
                .irq_req(fifo_irq_req[g])
            );
        end
    endgenerate

    // One wait cycle, then answer; keeps readdata registered
    always_comb begin
        next_state = state;
        next_rdata = rdata;
        next_mask = mask;
        next_pend = pend | (fifo_irq_req & ~req_d);
        case (state)
            CFI_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state = CFI_RESP;
                    next_rdata = `CFI_ZERO32;
                    if (avs_read && in_fifo)
                        next_rdata = slot_rd[idx];
                    else if (avs_read && avs_address == `CFI_OFS_PEND)
                        next_rdata = {16'h0000, pend};
                    else if (avs_read && avs_address == `CFI_OFS_MASK)
                        next_rdata = {16'h0000, mask};
                    if (avs_write && avs_address == `CFI_OFS_MASK)
                        next_mask = (avs_writedata[15:0] & be_mask[15:0])
                            | (mask & ~be_mask[15:0]);
                    if (avs_write && avs_address == `CFI_OFS_PEND)
                        next_pend = (pend & ~avs_writedata[15:0])
                            | (fifo_irq_req & ~req_d);
                end
            end
            CFI_RESP: next_state = CFI_IDLE;
            default: next_state = CFI_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= CFI_IDLE;
            rdata <= `CFI_ZERO32;
            pend <= 16'h0000;
            mask <= 16'h0000;
            req_d <= 16'h0000;
        end else begin
            state <= next_state;
            rdata <= next_rdata;
            pend <= next_pend;
            mask <= next_mask;
            req_d <= fifo_irq_req;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) && state == CFI_IDLE;
    assign avs_readdata = rdata;
    assign irq = |(pend & mask);

    property p_room_rx_zero;
        @(posedge clock) disable iff (!resetn)
            !fifo_direction_transmit[0]
            |-> !slot_rd[0][`CFI_B_TX_ROOM];
    endproperty
    a_room_rx_zero: assert property (p_room_rx_zero)
        else $error("room flag set in receive mode");

    property p_room_live;
        @(posedge clock) disable iff (!resetn)
            fifo_direction_transmit[0]
            |-> slot_rd[0][`CFI_B_TX_ROOM] == !fifo_full[0];
    endproperty
    a_room_live: assert property (p_room_live)
        else $error("room flag not live");

    property p_zero_bits;
        @(posedge clock) disable iff (!resetn)
            (slot_rd[3] & ~(`CFI_EN_TX_MASK | `CFI_EN_RX_MASK
            | `CFI_FLAG_MASK)) == `CFI_ZERO32;
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("unimplemented bit set");

    property p_ovr_sticky;
        @(posedge clock) disable iff (!resetn)
            slot_rd[0][`CFI_B_RX_OVR] && !slot_wr[0]
            |=> slot_rd[0][`CFI_B_RX_OVR];
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky)
        else $error("overrun dropped without write");

    property p_ovr_set;
        @(posedge clock) disable iff (!resetn)
            rx_overrun_event[0] && !fifo_direction_transmit[0]
            |=> slot_rd[0][`CFI_B_RX_OVR];
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun not latched");

    property p_en_write;
        @(posedge clock) disable iff (!resetn)
            slot_wr[1] && avs_byteenable == 4'hf |=>
            slot_rd[1][`CFI_B_TX_ROOM_EN:`CFI_B_TX_DRAIN_EN]
            == $past(avs_writedata[`CFI_B_TX_ROOM_EN:`CFI_B_TX_DRAIN_EN]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("tx enables not stored");

    property p_rx_en_write;
        @(posedge clock) disable iff (!resetn)
            slot_wr[2] && avs_byteenable == 4'hf |=>
            slot_rd[2][`CFI_B_RX_OVR_EN:`CFI_B_RX_PEND_EN]
            == $past(avs_writedata[`CFI_B_RX_OVR_EN:`CFI_B_RX_PEND_EN]);
    endproperty
    a_rx_en_write: assert property (p_rx_en_write)
        else $error("rx enables not stored");

    property p_indep;
        @(posedge clock) disable iff (!resetn)
            slot_wr[0]
            |-> slot_wr[15:1] == 15'h0000;
    endproperty
    a_indep: assert property (p_indep)
        else $error("write reached two slots");

    property p_pend_live;
        @(posedge clock) disable iff (!resetn)
            !fifo_direction_transmit[4]
            |-> slot_rd[4][`CFI_B_RX_PEND] == !fifo_empty[4];
    endproperty
    a_pend_live: assert property (p_pend_live)
        else $error("pending flag not live");

    property p_tx_half_live;
        @(posedge clock) disable iff (!resetn)
            fifo_direction_transmit[0]
            |-> slot_rd[0][`CFI_B_TX_HALF] == fifo_half[0];
    endproperty
    a_tx_half_live: assert property (p_tx_half_live)
        else $error("tx half flag not live");

    property p_drain_live;
        @(posedge clock) disable iff (!resetn)
            fifo_direction_transmit[0]
            |-> slot_rd[0][`CFI_B_TX_DRAIN] == fifo_empty[0];
    endproperty
    a_drain_live: assert property (p_drain_live)
        else $error("empty flag not live");

    property p_packed_live;
        @(posedge clock) disable iff (!resetn)
            !fifo_direction_transmit[4]
            |-> slot_rd[4][`CFI_B_RX_PACK] == fifo_full[4];
    endproperty
    a_packed_live: assert property (p_packed_live)
        else $error("full flag not live");

    property p_rx_half_live;
        @(posedge clock) disable iff (!resetn)
            !fifo_direction_transmit[4]
            |-> slot_rd[4][`CFI_B_RX_HALF] == fifo_half[4];
    endproperty
    a_rx_half_live: assert property (p_rx_half_live)
        else $error("rx half flag not live");

    // Receive FIFO 4 must hide the transmit half and drained views
    property p_tx_flags_rx;
        @(posedge clock) disable iff (!resetn)
            !fifo_direction_transmit[4]
            |-> !slot_rd[4][`CFI_B_TX_HALF] && !slot_rd[4][`CFI_B_TX_DRAIN];
    endproperty
    a_tx_flags_rx: assert property (p_tx_flags_rx)
        else $error("tx flag set in receive mode");

    property p_rx_flags_tx;
        @(posedge clock) disable iff (!resetn)
            fifo_direction_transmit[0]
            |-> !slot_rd[0][`CFI_B_RX_PACK] && !slot_rd[0][`CFI_B_RX_PEND];
    endproperty
    a_rx_flags_tx: assert property (p_rx_flags_tx)
        else $error("rx flag set in transmit mode");

    property p_irq_req_fifo1;
        @(posedge clock) disable iff (!resetn)
            fifo_irq_req[1] == (|(slot_rd[1][`CFI_B_TX_ROOM_EN:`CFI_B_TX_DRAIN_EN]
            & slot_rd[1][`CFI_B_TX_ROOM:`CFI_B_TX_DRAIN])
            || |(slot_rd[1][`CFI_B_RX_OVR_EN:`CFI_B_RX_PEND_EN]
            & slot_rd[1][`CFI_B_RX_OVR:`CFI_B_RX_PEND]));
    endproperty
    a_irq_req_fifo1: assert property (p_irq_req_fifo1)
        else $error("fifo request does not match flags");

    // Holes in the map must never leak stale data
    property p_unmapped_read;
        @(posedge clock) disable iff (!resetn)
            state == CFI_IDLE && avs_read && !in_fifo
            && avs_address != `CFI_OFS_PEND && avs_address != `CFI_OFS_MASK
            |=> avs_readdata == `CFI_ZERO32;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_zero_bits_last;
        @(posedge clock) disable iff (!resetn)
            (slot_rd[15] & ~(`CFI_EN_TX_MASK | `CFI_EN_RX_MASK
            | `CFI_FLAG_MASK)) == `CFI_ZERO32;
    endproperty
    a_zero_bits_last: assert property (p_zero_bits_last)
        else $error("unimplemented bit set in last slot");

    property p_ovr_clear;
        @(posedge clock) disable iff (!resetn)
            slot_wr[0] && !merged[`CFI_B_RX_OVR] && !rx_overrun_event[0]
            |=> !slot_rd[0][`CFI_B_RX_OVR];
    endproperty
    a_ovr_clear: assert property (p_ovr_clear)
        else $error("overrun not cleared by zero write");

    property p_ovr_tx_ignored;
        @(posedge clock) disable iff (!resetn)
            fifo_direction_transmit[0] && !slot_rd[0][`CFI_B_RX_OVR]
            |=> !slot_rd[0][`CFI_B_RX_OVR];
    endproperty
    a_ovr_tx_ignored: assert property (p_ovr_tx_ignored)
        else $error("overrun latched in transmit mode");

    property p_rx_en_hold;
        @(posedge clock) disable iff (!resetn)
            !slot_wr[2]
            |=> $stable(slot_rd[2][`CFI_B_RX_OVR_EN:`CFI_B_RX_PEND_EN]);
    endproperty
    a_rx_en_hold: assert property (p_rx_en_hold)
        else $error("rx enables changed without write");

    property p_tx_en_hold;
        @(posedge clock) disable iff (!resetn)
            !slot_wr[1]
            |=> $stable(slot_rd[1][`CFI_B_TX_ROOM_EN:`CFI_B_TX_DRAIN_EN]);
    endproperty
    a_tx_en_hold: assert property (p_tx_en_hold)
        else $error("tx enables changed without write");
endmodule

// File: verif/cfi_fifo_model.sv
`timescale 1ns/1ps
module cfi_fifo_model
    import cfi_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire cfi_pkg::cfi_vec_t push,
    input wire cfi_pkg::cfi_vec_t pop,
    input wire cfi_pkg::cfi_vec_t fifo_direction_transmit,
    output cfi_pkg::cfi_vec_t fifo_full,
    output cfi_pkg::cfi_vec_t fifo_half,
    output cfi_pkg::cfi_vec_t fifo_empty,
    output cfi_pkg::cfi_vec_t rx_overrun_event
);
    int level [16];
    // A push into a full receive FIFO is dropped and reported as overrun
    always_ff @(posedge clock or negedge resetn) begin
        for (int n = 0; n < 16; n++) begin
            if (!resetn) begin
                level[n] <= 0;
                rx_overrun_event[n] <= 1'b0;
            end else begin
                rx_overrun_event[n] <= push[n] && level[n] == DEPTH
                    && !fifo_direction_transmit[n];
                if (push[n] && level[n] < DEPTH)
                    level[n] <= level[n] + 1;
                else if (pop[n] && level[n] > 0)
                    level[n] <= level[n] - 1;
            end
        end
    end
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            fifo_full[n] = level[n] == DEPTH;
            fifo_half[n] = level[n] >= DEPTH / 2;
            fifo_empty[n] = level[n] == 0;
        end
    end
endmodule

// File: verif/can_fifo_interrupt_flags_test.sv
`timescale 1ns/1ps
`include "cfi_regs.svh"
module can_fifo_interrupt_flags_test;
    import cfi_pkg::*;
    logic clock = 0, resetn = 0, avs_read = 0, avs_write = 0;
    logic avs_waitrequest, irq;
    logic [7:0] avs_address = 8'h00;
    logic [3:0] avs_byteenable = 4'hf, lanes = 4'hf;
    cfi_word_t avs_writedata = 32'h0, avs_readdata, q, w;
    cfi_vec_t dir = 16'h5555, push = 16'h0, pop = 16'h0;
    cfi_vec_t full, half, empty, ovr_ev, irq_req;
    cfi_word_t en [16];
    logic ovr [16];
    int n_errors = 0, n_compared = 0, cycles = 0;
    always #20 clock = ~clock;
    cfi_top cfi_top_i (.clock(clock), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fifo_direction_transmit(dir),
        .fifo_full(full), .fifo_half(half), .fifo_empty(empty),
        .rx_overrun_event(ovr_ev), .fifo_irq_req(irq_req), .irq(irq));
    cfi_fifo_model cfi_fifo_model_i (.clock(clock), .resetn(resetn),
        .push(push), .pop(pop), .fifo_direction_transmit(dir),
        .fifo_full(full), .fifo_half(half), .fifo_empty(empty),
        .rx_overrun_event(ovr_ev));
    task complete_run;
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run;
        end
    end
    task check(input cfi_word_t seen, input cfi_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input cfi_word_t d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= lanes;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Live flags differ by direction; only overrun is held
    function automatic cfi_word_t exp_word(int n);
        cfi_word_t x;
        x = en[n] & (`CFI_EN_TX_MASK | `CFI_EN_RX_MASK);
        if (dir[n]) begin
            x[10] = !full[n];
            x[9] = half[n];
            x[8] = empty[n];
        end else begin
            x[3] = ovr[n];
            x[2] = full[n];
            x[1] = half[n];
            x[0] = !empty[n];
        end
        return x;
    endfunction
    task read_fifo(input int n);
        bus(1'b0, 8'(4 * n), 32'h0);
        w = exp_word(n);
        check(q, w);
        check(32'(irq_req[n]), 32'(|(w[26:24] & w[10:8])
            || |(w[19:16] & w[3:0])));
    endtask
    task fifo_op(input int n, input logic is_push, input int times);
        repeat (times) begin
            @(posedge clock);
            if (is_push)
                push <= 16'h1 << n;
            else
                pop <= 16'h1 << n;
        end
        @(posedge clock);
        push <= 16'h0;
        pop <= 16'h0;
    endtask
    initial begin
        for (int n = 0; n < 16; n++) ovr[n] = 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            en[n] = 32'h0;
            read_fifo(n);
        end
        for (int n = 0; n < 16; n++) begin
            en[n] = {5'h1f, 3'(n), 4'hf, 4'(n), 16'hffff};
            bus(1'b1, 8'(4 * n), en[n]);
        end
        for (int n = 0; n < 16; n++) read_fifo(n);
        fifo_op(0, 1'b1, 2);
        read_fifo(0);
        fifo_op(0, 1'b1, 2);
        read_fifo(0);
        fifo_op(0, 1'b0, 4);
        read_fifo(0);
        bus(1'b1, `CFI_OFS_PEND, 32'h0000_ffff);
        bus(1'b1, `CFI_OFS_MASK, 32'h0000_0002);
        fifo_op(1, 1'b1, 1);
        read_fifo(1);
        bus(1'b0, `CFI_OFS_PEND, 32'h0);
        check(q, 32'h0000_0002);
        check(32'(irq), 32'h1);
        bus(1'b1, `CFI_OFS_PEND, 32'h0000_0002);
        check(32'(irq), 32'h0);
        fifo_op(1, 1'b1, 4);
        repeat (2) @(posedge clock);
        ovr[1] = 1'b1;
        read_fifo(1);
        fifo_op(1, 1'b0, 4);
        read_fifo(1);
        bus(1'b1, 8'h04, en[1]);
        read_fifo(1);
        bus(1'b1, 8'h04, en[1] & 32'hffff_fff7);
        ovr[1] = 1'b0;
        read_fifo(1);
        lanes = 4'b0100;
        en[2] = en[2] & 32'hff00_ffff;
        bus(1'b1, 8'h08, 32'h0);
        lanes = 4'b0010;
        bus(1'b1, `CFI_OFS_MASK, 32'h0000_ff00);
        lanes = 4'hf;
        read_fifo(2);
        bus(1'b0, `CFI_OFS_MASK, 32'h0);
        check(q, 32'h0000_ff02);
        bus(1'b1, 8'h80, 32'hffff_ffff);
        bus(1'b0, 8'h80, 32'h0);
        check(q, 32'h0);
        complete_run;
    end
endmodule
